/* File: src/rsso_core.sv */
// Purpose: Executes rotate right, literal minus W and sleep, with AXI4-Lite access.
// Assumes: Inputs synchronous to aclk; master keeps valid and payload until taken.
// Notes: A command write with byte strobes 0 to 2 all set, taken while running, executes in that cycle; one taken while asleep is not executed.
`timescale 1ns/1ps
module rsso_core (
	input wire logic aclk, // Core clock, 25 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic ce, // Clock enable, freezes all state while low
	input wire logic wake, // Wake event that ends sleep
	input wire logic [rsso_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [rsso_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic osc_stop, // Main oscillator halted while high
	output logic wdt_clear // One-cycle pulse clearing the watchdog
);
	import rsso_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic awready_ff, nxt_awready;
	logic wready_ff, nxt_wready;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic arready_ff, nxt_arready;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;

	rsso_state_t state_ff, nxt_state;
	logic [7:0] w_ff, nxt_w;
	logic c_ff, nxt_c;
	logic digit_carry_flag_ff, nxt_digit_carry_flag;
	logic z_ff, nxt_z;
	logic power_down_flag_n_ff, nxt_power_down_flag_n;
	logic to_n_ff, nxt_to_n;
	logic osc_ff, nxt_osc;
	logic wdtclr_ff, nxt_wdtclr;
	logic [7:0] pre_ff, nxt_pre;
	logic [7:0] wdt_ff, nxt_wdt;
	logic [6:0] faddr_ff, nxt_faddr;
	logic [CMD_W-1:0] cmd_ff, nxt_cmd;

	logic [7:0] file_mem [FILE_DEPTH];
	logic file_we;
	logic [7:0] file_wdata;
	logic [6:0] file_waddr;
	logic [7:0] fval;

	logic wr_go, rd_go, exec_go;
	rsso_op_t cmd_op;
	logic cmd_d;
	logic [6:0] cmd_f;
	logic [7:0] cmd_lit;

	rsso_alu_if alu_bus();

	rsso_alu u_alu (
		.alu(alu_bus)
	);

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == ADDR_CMD) || (a == ADDR_WREG) || (a == ADDR_STATUS) ||
			(a == ADDR_FADDR) || (a == ADDR_FDATA) || (a == ADDR_WDT);
	endfunction

	// ----------------------------------------------------------------
	// Command decode and datapath hookup
	// ----------------------------------------------------------------
	assign wr_go = awready_ff && s_axi_awvalid && wready_ff && s_axi_wvalid;
	assign rd_go = arready_ff && s_axi_arvalid;
	assign cmd_op = rsso_op_t'(s_axi_wdata[CMD_OP_LSB +: 2]);
	assign cmd_d = s_axi_wdata[CMD_D_BIT];
	assign cmd_f = s_axi_wdata[CMD_F_LSB +: FILE_AW];
	assign cmd_lit = s_axi_wdata[CMD_LIT_LSB +: 8];
	assign exec_go = ce && wr_go && (s_axi_awaddr == ADDR_CMD) && (s_axi_wstrb[2:0] == 3'h7)
		&& (state_ff == RSSO_RUN);
	assign fval = file_mem[cmd_f];

	assign alu_bus.op = exec_go ? cmd_op : RSSO_OP_NONE;
	assign alu_bus.lit = cmd_lit;
	assign alu_bus.fval = fval;
	assign alu_bus.w = w_ff;
	assign alu_bus.c_in = c_ff;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	always_comb begin
		nxt_awready = 1'b0;
		nxt_wready = 1'b0;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_arready = 1'b0;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		// Both channels are taken together so one response covers one write.
		if (s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff) begin
			nxt_awready = 1'b1;
			nxt_wready = 1'b1;
		end
		if (wr_go) begin
			nxt_bvalid = 1'b1;
			nxt_bresp = is_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		if (s_axi_arvalid && !arready_ff && !rvalid_ff) begin
			nxt_arready = 1'b1;
		end
		if (rd_go) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				ADDR_CMD: nxt_rdata = {14'h0000, cmd_ff};
				ADDR_WREG: nxt_rdata = {24'h000000, w_ff};
				ADDR_STATUS: nxt_rdata = {26'h0000000, (state_ff == RSSO_ASLEEP),
					to_n_ff, power_down_flag_n_ff, z_ff, digit_carry_flag_ff, c_ff};
				ADDR_FADDR: nxt_rdata = {25'h0000000, faddr_ff};
				ADDR_FDATA: nxt_rdata = {24'h000000, file_mem[faddr_ff]};
				ADDR_WDT: nxt_rdata = {16'h0000, wdt_ff, pre_ff};
				default: nxt_rdata = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Core state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_w = w_ff;
		nxt_c = c_ff;
		nxt_digit_carry_flag = digit_carry_flag_ff;
		nxt_z = z_ff;
		nxt_power_down_flag_n = power_down_flag_n_ff;
		nxt_to_n = to_n_ff;
		nxt_osc = osc_ff;
		nxt_wdtclr = 1'b0;
		nxt_faddr = faddr_ff;
		nxt_cmd = cmd_ff;
		nxt_pre = pre_ff + 8'h01;
		nxt_wdt = (pre_ff == 8'hff) ? wdt_ff + 8'h01 : wdt_ff;
		file_we = 1'b0;
		file_waddr = faddr_ff;
		file_wdata = s_axi_wdata[7:0];
		case (state_ff)
			RSSO_RUN: begin
				// One bus word, done in one cycle.
				if (exec_go) begin
					nxt_cmd = s_axi_wdata[CMD_W-1:0];
					case (cmd_op)
						RSSO_OP_ROTATE_RIGHT_CARRY: begin
							nxt_c = alu_bus.c_out;
							if (cmd_d) begin
								file_we = 1'b1;
								file_waddr = cmd_f;
								file_wdata = alu_bus.res;
							end else begin
								nxt_w = alu_bus.res;
							end
						end
						RSSO_OP_LITERAL_MINUS_W: begin
							nxt_w = alu_bus.res;
							nxt_c = alu_bus.c_out;
							if (alu_bus.upd_dcz) begin
								nxt_digit_carry_flag = alu_bus.digit_carry_out;
								nxt_z = alu_bus.z_out;
							end
						end
						RSSO_OP_SLEEP: begin
							nxt_power_down_flag_n = 1'b0;
							nxt_to_n = 1'b1;
							nxt_pre = 8'h00;
							nxt_wdt = 8'h00;
							nxt_wdtclr = 1'b1;
							nxt_osc = 1'b1;
							nxt_state = RSSO_ASLEEP;
						end
						default: begin
						end
					endcase
				end
			end
			RSSO_ASLEEP: begin
				if (wake) begin
					nxt_osc = 1'b0;
					nxt_state = RSSO_RUN;
				end
			end
			default: nxt_state = RSSO_RUN;
		endcase
		if (wr_go && !exec_go) begin
			case (s_axi_awaddr)
				ADDR_WREG: if (s_axi_wstrb[0]) nxt_w = s_axi_wdata[7:0];
				ADDR_STATUS: if (s_axi_wstrb[0]) begin
					nxt_c = s_axi_wdata[ST_C];
					nxt_digit_carry_flag = s_axi_wdata[ST_DIGIT_CARRY];
					nxt_z = s_axi_wdata[ST_Z];
				end
				ADDR_FADDR: if (s_axi_wstrb[0]) nxt_faddr = s_axi_wdata[FILE_AW-1:0];
				ADDR_FDATA: file_we = s_axi_wstrb[0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= RESP_OKAY;
			state_ff <= RSSO_RUN;
			w_ff <= RST_WREG;
			c_ff <= 1'b0;
			digit_carry_flag_ff <= 1'b0;
			z_ff <= 1'b0;
			power_down_flag_n_ff <= RST_FLAG_N;
			to_n_ff <= RST_FLAG_N;
			osc_ff <= 1'b0;
			wdtclr_ff <= 1'b0;
			pre_ff <= RST_WDT;
			wdt_ff <= RST_WDT;
			faddr_ff <= RST_FADDR;
			cmd_ff <= '0;
		end else if (ce) begin
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			arready_ff <= nxt_arready;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			state_ff <= nxt_state;
			w_ff <= nxt_w;
			c_ff <= nxt_c;
			digit_carry_flag_ff <= nxt_digit_carry_flag;
			z_ff <= nxt_z;
			power_down_flag_n_ff <= nxt_power_down_flag_n;
			to_n_ff <= nxt_to_n;
			osc_ff <= nxt_osc;
			wdtclr_ff <= nxt_wdtclr;
			pre_ff <= nxt_pre;
			wdt_ff <= nxt_wdt;
			faddr_ff <= nxt_faddr;
			cmd_ff <= nxt_cmd;
		end
	end

	// File contents are data, so they carry no reset.
	always_ff @(posedge aclk) begin
		if (ce && aresetn && file_we) begin
			file_mem[file_waddr] <= file_wdata;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign osc_stop = osc_ff;
	assign wdt_clear = wdtclr_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_rotate_result: assert property (
		exec_go && cmd_op == RSSO_OP_ROTATE_RIGHT_CARRY && !cmd_d
		|=> w_ff == {$past(c_ff), $past(fval[7:1])} && c_ff == $past(fval[0]))
		else $error("rotate result or carry wrong");
	chk_rotate_flags_kept: assert property (
		exec_go && cmd_op == RSSO_OP_ROTATE_RIGHT_CARRY
		|=> $stable(digit_carry_flag_ff) && $stable(z_ff))
		else $error("rotate changed digit-carry or zero");
	chk_rotate_file_dest: assert property (
		exec_go && cmd_op == RSSO_OP_ROTATE_RIGHT_CARRY && cmd_d
		|=> $stable(w_ff) && file_mem[$past(cmd_f)] == {$past(c_ff), $past(fval[7:1])})
		else $error("rotate to file register wrong");
	chk_sub_result: assert property (
		exec_go && cmd_op == RSSO_OP_LITERAL_MINUS_W
		|=> w_ff == 8'($past(cmd_lit) - $past(w_ff)) && c_ff == ($past(w_ff) <= $past(cmd_lit))
		&& digit_carry_flag_ff == ($past(w_ff[3:0]) <= $past(cmd_lit[3:0]))
		&& z_ff == (w_ff == 8'h00))
		else $error("literal subtract result or flags wrong");
	chk_sleep_flags: assert property (
		exec_go && cmd_op == RSSO_OP_SLEEP |=> !power_down_flag_n_ff && to_n_ff)
		else $error("sleep status flags wrong");
	chk_sleep_wdt: assert property (
		exec_go && cmd_op == RSSO_OP_SLEEP |=> wdt_ff == 8'h00 && pre_ff == 8'h00 && wdt_clear)
		else $error("sleep did not clear watchdog");
	chk_sleep_osc: assert property (
		exec_go && cmd_op == RSSO_OP_SLEEP ##1 !wake [*2] |-> osc_stop && state_ff == RSSO_ASLEEP)
		else $error("oscillator not halted in sleep");
	// A command written while asleep must leave cmd_ff, W, carry and zero untouched.
	chk_sleep_no_exec: assert property (
		state_ff == RSSO_ASLEEP && wr_go && s_axi_awaddr == ADDR_CMD
		|=> $stable(cmd_ff) && $stable(w_ff) && $stable(c_ff) && $stable(z_ff))
		else $error("instruction executed while asleep");
	chk_one_cycle: assert property (
		ce && wr_go && s_axi_awaddr == ADDR_CMD && s_axi_wstrb[2:0] == 3'h7 && state_ff == RSSO_RUN
		|=> cmd_ff == $past(s_axi_wdata[CMD_W-1:0]) && s_axi_bvalid)
		else $error("command not completed in one cycle");

endmodule

/* File: src/rsso_pkg.sv */
// Purpose: Constants and types shared by the rotate, subtract and sleep execution block.
// Assumes: One 25 MHz core clock and 32-bit AXI4-Lite register access.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package rsso_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_WREG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_FADDR = 8'h0c;
	localparam logic [7:0] ADDR_FDATA = 8'h10;
	localparam logic [7:0] ADDR_WDT = 8'h14;

	// ----------------------------------------------------------------
	// Field layouts
	// ----------------------------------------------------------------
	localparam int CMD_LIT_LSB = 0;
	localparam int CMD_F_LSB = 8;
	localparam int CMD_D_BIT = 15;
	localparam int CMD_OP_LSB = 16;
	localparam int CMD_W = 18;
	localparam int ST_C = 0;
	localparam int ST_DIGIT_CARRY = 1;
	localparam int ST_Z = 2;
	localparam int ST_POWER_DOWN = 3;
	localparam int ST_TO = 4;
	localparam int ST_SLEEP = 5;
	localparam int FILE_AW = 7;
	localparam int FILE_DEPTH = 128;

	// ----------------------------------------------------------------
	// Reset values and responses
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_WREG = 8'h00;
	localparam logic [6:0] RST_FADDR = 7'h00;
	localparam logic [7:0] RST_WDT = 8'h00;
	localparam logic RST_FLAG_N = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		RSSO_OP_ROTATE_RIGHT_CARRY,
		RSSO_OP_LITERAL_MINUS_W,
		RSSO_OP_SLEEP,
		RSSO_OP_NONE
	} rsso_op_t;

	typedef enum logic {
		RSSO_RUN,
		RSSO_ASLEEP
	} rsso_state_t;

endpackage

/* File: src/rsso_alu_if.sv */
// Purpose: Carries one instruction's operands to the datapath and its results back.
// Assumes: Purely combinational datapath on the far side.
// Notes: The core drives operands, the datapath drives results.
`timescale 1ns/1ps
interface rsso_alu_if;
	import rsso_pkg::*;
	rsso_op_t op;
	logic [7:0] lit;
	logic [7:0] fval;
	logic [7:0] w;
	logic c_in;
	logic [7:0] res;
	logic c_out;
	logic digit_carry_out;
	logic z_out;
	logic upd_dcz;

	modport core(output op, output lit, output fval, output w, output c_in,
		input res, input c_out, input digit_carry_out, input z_out, input upd_dcz);
	modport alu(input op, input lit, input fval, input w, input c_in,
		output res, output c_out, output digit_carry_out, output z_out, output upd_dcz);
endinterface

/* File: src/rsso_alu.sv */
// Purpose: Combinational datapath for rotate right through carry and literal minus W.
// Assumes: Operands are stable for the cycle in which the core executes.
// Notes: Other opcodes pass the file value and the carry through untouched.
`timescale 1ns/1ps
module rsso_alu (
	rsso_alu_if.alu alu // Operands in, results out
);
	import rsso_pkg::*;

	logic [8:0] diff;
	logic [4:0] ldiff;

	always_comb begin
		diff = {1'b0, alu.lit} - {1'b0, alu.w};
		ldiff = {1'b0, alu.lit[3:0]} - {1'b0, alu.w[3:0]};
		alu.res = alu.fval;
		alu.c_out = alu.c_in;
		alu.digit_carry_out = 1'b0;
		alu.z_out = 1'b0;
		alu.upd_dcz = 1'b0;
		case (alu.op)
			RSSO_OP_ROTATE_RIGHT_CARRY: begin
				alu.res = {alu.c_in, alu.fval[7:1]};
				alu.c_out = alu.fval[0];
			end
			RSSO_OP_LITERAL_MINUS_W: begin
				alu.res = diff[7:0];
				alu.c_out = ~diff[8];
				alu.digit_carry_out = ~ldiff[4];
				alu.z_out = (diff[7:0] == 8'h00);
				alu.upd_dcz = 1'b1;
			end
			default: begin
			end
		endcase
	end

endmodule

/* File: verification/test_rotate_subtract_sleep_ops.sv */
// Purpose: Self-checking bench for rotate, literal subtract and sleep execution.
// Assumes: One write and one read outstanding at most; bready and rready stay high.
// Notes: Ordinary instruction cases are table rows; sleep and reset are written by hand.
`timescale 1ns/1ps
module test_rotate_subtract_sleep_ops;
	import rsso_pkg::*;

	// ------------------------------------------------------------
	// Stimulus table
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] op;
		logic d;
		logic [7:0] lit;
		logic [6:0] fa;
		logic [7:0] fv;
		logic [7:0] w;
		logic [2:0] st;
		logic [7:0] ew;
		logic [7:0] ef;
		logic [5:0] est;
	} rsso_row_t;

	// Status inputs are chosen so that a flag updated by mistake shows a change.
	rsso_row_t rows [10] = '{
		'{2'h0, 1'b0, 8'ha5, 7'h05, 8'he6, 8'h11, 3'h6, 8'h73, 8'he6, 6'h1e},
		'{2'h0, 1'b1, 8'h00, 7'h7f, 8'h01, 8'h22, 3'h1, 8'h22, 8'h80, 6'h19},
		'{2'h0, 1'b1, 8'h00, 7'h00, 8'h00, 8'h55, 3'h0, 8'h55, 8'h00, 6'h18},
		'{2'h0, 1'b0, 8'h00, 7'h09, 8'h81, 8'h00, 3'h7, 8'hc0, 8'h81, 6'h1f},
		'{2'h1, 1'b1, 8'h10, 7'h20, 8'haa, 8'h10, 3'h0, 8'h00, 8'haa, 6'h1f},
		'{2'h1, 1'b0, 8'h05, 7'h21, 8'h3c, 8'h06, 3'h7, 8'hff, 8'h3c, 6'h18},
		'{2'h1, 1'b0, 8'h30, 7'h22, 8'h11, 8'h0f, 3'h2, 8'h21, 8'h11, 6'h19},
		'{2'h1, 1'b0, 8'h2f, 7'h23, 8'h12, 8'h31, 3'h5, 8'hfe, 8'h12, 6'h1a},
		'{2'h1, 1'b0, 8'hff, 7'h24, 8'h13, 8'h00, 3'h0, 8'hff, 8'h13, 6'h1b},
		'{2'h3, 1'b1, 8'h00, 7'h25, 8'h12, 8'h44, 3'h3, 8'h44, 8'h12, 6'h1b}
	};

	logic aclk, aresetn, ce, wake;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, osc_stop, wdt_clear;
	logic [1:0] bresp, rresp;
	int errors, compares, clears, n;
	rsso_row_t r;

	rsso_core rsso_core_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.wake(wake),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.osc_stop(osc_stop),
		.wdt_clear(wdt_clear)
	);

	// ------------------------------------------------------------
	// Clock, pulse counter and shared tasks
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (wdt_clear === 1'b1) begin
			clears++;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task results();
		if (errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Both channels are offered together and each is dropped when its ready is seen.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		k = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && k < 50);
		if (bvalid !== 1'b1) begin
			errors++;
			results();
		end else begin
			chk({30'h0, bresp}, {30'h0, er}, "bresp");
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		int k;
		k = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && k < 50);
		if (rvalid !== 1'b1) begin
			errors++;
			results();
		end else begin
			d = rdata;
			chk({30'h0, rresp}, {30'h0, er}, "rresp");
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		wake = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b1;
		rready = 1'b1;
		errors = 0;
		compares = 0;
		clears = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ADDR_WREG, RESP_OKAY, v);
		chk(v, 32'h0, "reset w");
		rd(ADDR_STATUS, RESP_OKAY, v);
		chk(v, 32'h18, "reset status");
		chk({31'h0, osc_stop}, 32'h0, "reset osc");
		foreach (rows[i]) begin
			r = rows[i];
			wr(ADDR_WREG, {24'h0, r.w}, RESP_OKAY);
			wr(ADDR_STATUS, {29'h0, r.st}, RESP_OKAY);
			wr(ADDR_FADDR, {25'h0, r.fa}, RESP_OKAY);
			wr(ADDR_FDATA, {24'h0, r.fv}, RESP_OKAY);
			wr(ADDR_CMD, {14'h0, r.op, r.d, r.fa, r.lit}, RESP_OKAY);
			rd(ADDR_WREG, RESP_OKAY, v);
			chk(v, {24'h0, r.ew}, "row w");
			rd(ADDR_FDATA, RESP_OKAY, v);
			chk(v, {24'h0, r.ef}, "row file");
			rd(ADDR_STATUS, RESP_OKAY, v);
			chk(v, {26'h0, r.est}, "row status");
		end
		wr(8'h40, 32'h1, RESP_SLVERR);
		rd(8'h40, RESP_SLVERR, v);
		chk(v, 32'h0, "unmapped read");
		// Back-to-back: the rotate must see the carry left by the subtract just before.
		wr(ADDR_WREG, 32'h10, RESP_OKAY);
		wr(ADDR_FADDR, 32'h03, RESP_OKAY);
		wr(ADDR_FDATA, 32'h02, RESP_OKAY);
		wr(ADDR_CMD, 32'h0001_0310, RESP_OKAY);
		wr(ADDR_CMD, 32'h0000_0300, RESP_OKAY);
		rd(ADDR_WREG, RESP_OKAY, v);
		chk(v, 32'h81, "chained w");
		rd(ADDR_STATUS, RESP_OKAY, v);
		chk(v, 32'h1e, "chained status");
		wr(ADDR_CMD, 32'h0002_0000, RESP_OKAY);
		chk({31'h0, osc_stop}, 32'h1, "osc after sleep");
		rd(ADDR_STATUS, RESP_OKAY, v);
		chk(v, 32'h36, "sleep status");
		rd(ADDR_WDT, RESP_OKAY, v);
		chk({v[31:8], v[7:4]}, 32'h0, "watchdog after sleep");
		chk(clears, 1, "clear pulses");
		wr(ADDR_CMD, 32'h0001_0300, RESP_OKAY);
		rd(ADDR_WREG, RESP_OKAY, v);
		chk(v, 32'h81, "asleep w");
		wake <= 1'b1;
		@(posedge aclk);
		wake <= 1'b0;
		for (n = 0; n < 8 && osc_stop !== 1'b0; n++) begin
			@(posedge aclk);
		end
		chk({31'h0, osc_stop}, 32'h0, "osc after wake");
		wr(ADDR_CMD, 32'h0001_0381, RESP_OKAY);
		rd(ADDR_STATUS, RESP_OKAY, v);
		chk(v, 32'h17, "awake status");
		// A reset while asleep must restart the core awake with both flags set.
		wr(ADDR_CMD, 32'h0002_0000, RESP_OKAY);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ADDR_STATUS, RESP_OKAY, v);
		chk(v, 32'h18, "status after reset");
		chk({31'h0, osc_stop}, 32'h0, "osc after reset");
		chk(clears, 2, "second clear pulse");
		results();
	end
endmodule
